// ==== hdl/tmw_pkg.sv ====
// shared constants and carrier types for the 8-bit timer waveform block
package tmw_pkg;
	localparam logic [7:0] TMW_BOTTOM    = 8'h00;
	localparam logic [7:0] TMW_MAX       = 8'hff;
	localparam logic [7:0] TMW_CNT_RST   = 8'h00;
	localparam logic [7:0] TMW_OCR_RST   = 8'h00;
	localparam logic       TMW_WAVE_RST  = 1'b0;
	// prescale divide counts, one per dividing clock_select code (2 to 7)
	localparam logic [9:0] TMW_DIV_8     = 10'h007;
	localparam logic [9:0] TMW_DIV_32    = 10'h01f;
	localparam logic [9:0] TMW_DIV_64    = 10'h03f;
	localparam logic [9:0] TMW_DIV_128   = 10'h07f;
	localparam logic [9:0] TMW_DIV_256   = 10'h0ff;
	localparam logic [9:0] TMW_DIV_1024  = 10'h3ff;
	localparam int         TMW_CHANNELS  = 2;

	typedef enum logic [2:0] {
		TMW_NORMAL  = 3'b000,
		TMW_PC_FF   = 3'b001,
		TMW_CTC     = 3'b010,
		TMW_FAST_FF = 3'b011,
		TMW_RSVD4   = 3'b100,
		TMW_PC_OCRA = 3'b101,
		TMW_RSVD6   = 3'b110,
		TMW_FAST_OC = 3'b111
	} tmw_mode_t;

	// software write of the count register
	typedef struct packed {
		logic       wr;
		logic [7:0] data;
	} tmw_cnt_wr_t;

	// per-channel compare configuration
	typedef struct packed {
		logic       wr;
		logic [7:0] data;
		logic [1:0] action;
		logic       dir_out;
	} tmw_chan_cfg_t;
endpackage

// ==== hdl/tmw_timer8.sv ====
// waveform generation core of an 8-bit timer with two compare channels
`timescale 1ns/1ps
module tmw_timer8 (
	input  wire logic                   clk_in,
	input  wire logic                   resetn_in,
	input  wire logic [2:0]             clock_select_in,
	input  wire logic [2:0]             waveform_mode_select_in,
	input  wire tmw_pkg::tmw_cnt_wr_t   cnt_wr_in,
	input  wire tmw_pkg::tmw_chan_cfg_t chan_a_in,
	input  wire tmw_pkg::tmw_chan_cfg_t chan_b_in,
	input  wire logic                   overflow_clear_in,
	input  wire logic [1:0]             compare_clear_in,
	output logic [7:0]                  counter_value_out,
	output logic [7:0]                  compare_a_value_out,
	output logic [7:0]                  compare_b_value_out,
	output logic                        overflow_flag_out,
	output logic [1:0]                  compare_flag_out,
	output logic [1:0]                  wave_output_out,
	output logic [1:0]                  pin_drive_out,
	output logic [1:0]                  pin_oe_out,
	output logic                        timer_tick_out
);
	import tmw_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// prescaler and timer tick

	logic [9:0]  prescale;
	logic [9:0]  div_limit;
	logic        tick;
	tmw_mode_t   mode;

	assign mode = tmw_mode_t'(waveform_mode_select_in);

	// divide limit picked from clock_select; 0 stops and 1 is undivided
	always_comb begin
		case (clock_select_in)
			3'h2:    div_limit = TMW_DIV_8;
			3'h3:    div_limit = TMW_DIV_32;
			3'h4:    div_limit = TMW_DIV_64;
			3'h5:    div_limit = TMW_DIV_128;
			3'h6:    div_limit = TMW_DIV_256;
			3'h7:    div_limit = TMW_DIV_1024;
			default: div_limit = 10'h000;
		endcase
	end

	// free running divider, restarts when stopped so a start is predictable
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			prescale <= 10'h000;
		end else if (clock_select_in == 3'h0 || prescale >= div_limit) begin
			prescale <= 10'h000;
		end else begin
			prescale <= prescale + 10'h001;
		end
	end

	assign tick = (clock_select_in != 3'h0) && (prescale >= div_limit);
	assign timer_tick_out = tick;

	////////////////////////////////////////////////////////////////////////////////
	// mode decode

	logic       is_pwm;
	logic       is_fast;
	logic       is_pc;
	logic [7:0] top;
	logic [7:0] cnt;
	logic       count_down;
	logic       block_match;
	logic [7:0] ocr_act [TMW_CHANNELS];
	logic [7:0] ocr_buf [TMW_CHANNELS];

	// only the mode select shapes counting; action bits are never read here
	assign is_fast = (mode == TMW_FAST_FF) || (mode == TMW_FAST_OC);
	assign is_pc   = (mode == TMW_PC_FF) || (mode == TMW_PC_OCRA);
	assign is_pwm  = is_fast || is_pc;

	// top from the active compare a in the ocra-topped modes
	always_comb begin
		case (mode)
			TMW_CTC, TMW_FAST_OC, TMW_PC_OCRA: top = ocr_act[0];
			default:                           top = TMW_MAX;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////////
	// counter unit

	logic [7:0] next_cnt;
	logic       next_down;

	// next count on a tick; writes are handled with priority in the register
	always_comb begin
		next_cnt  = cnt;
		next_down = count_down;
		if (is_fast) begin
			next_cnt = (cnt == top) ? TMW_BOTTOM : cnt + 8'h01;
		end else if (is_pc) begin
			if (!count_down && cnt >= top) begin
				next_down = 1'b1;
				next_cnt  = (top == TMW_BOTTOM) ? TMW_BOTTOM : cnt - 8'h01;
			end else if (count_down && cnt == TMW_BOTTOM) begin
				next_down = 1'b0;
				next_cnt  = cnt + 8'h01;
			end else begin
				next_cnt = count_down ? cnt - 8'h01 : cnt + 8'h01;
			end
		end else if (mode == TMW_CTC && cnt == top && !block_match) begin
			// a blocked match must not clear either, or a write equal to top is lost
			next_cnt = TMW_BOTTOM;
		end else begin
			next_cnt = cnt + 8'h01;
		end
	end

	// software write beats clear and count, even while stopped
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			cnt        <= TMW_CNT_RST;
			count_down <= 1'b0;
		end else if (cnt_wr_in.wr) begin
			cnt <= cnt_wr_in.data;
			if (!is_pc) begin
				count_down <= 1'b0;
			end
		end else if (tick) begin
			cnt        <= next_cnt;
			count_down <= is_pc ? next_down : 1'b0;
		end
	end

	// a write arms a block that covers the next timer tick
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			block_match <= 1'b0;
		end else if (cnt_wr_in.wr) begin
			block_match <= 1'b1;
		end else if (tick) begin
			block_match <= 1'b0;
		end
	end

	assign counter_value_out = cnt;

	////////////////////////////////////////////////////////////////////////////////
	// overflow flag

	logic ovf_event;

	// set at max in normal/ctc unless ctc clears there at top, at top in fast pwm, at bottom in phase correct
	always_comb begin
		if (is_fast) begin
			ovf_event = tick && !cnt_wr_in.wr && (cnt == top);
		end else if (is_pc) begin
			ovf_event = tick && !cnt_wr_in.wr && count_down && cnt == TMW_BOTTOM;
		end else begin
			ovf_event = tick && !cnt_wr_in.wr && (cnt == TMW_MAX) &&
				!(mode == TMW_CTC && cnt == top);
		end
	end

	// set wins over a clear in the same cycle
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			overflow_flag_out <= 1'b0;
		end else if (ovf_event) begin
			overflow_flag_out <= 1'b1;
		end else if (overflow_clear_in) begin
			overflow_flag_out <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// compare channels

	tmw_chan_cfg_t cfg [TMW_CHANNELS];
	logic          bottom_tick;
	logic          top_tick;

	assign cfg[0] = chan_a_in;
	assign cfg[1] = chan_b_in;

	// buffer update points: top for phase correct, bottom wrap for fast pwm
	assign top_tick    = tick && is_pc && !count_down && cnt >= top;
	assign bottom_tick = tick && is_fast && cnt == top;

	genvar ch;
	generate
		for (ch = 0; ch < TMW_CHANNELS; ch++) begin : g_chan
			logic match;
			logic wave;
			logic next_wave;
			logic up_hit;
			logic pc_down;

			// buffer takes writes; active copy follows at once outside pwm, else at the update point
			always_ff @(posedge clk_in or negedge resetn_in) begin
				if (!resetn_in) begin
					ocr_buf[ch] <= TMW_OCR_RST;
					ocr_act[ch] <= TMW_OCR_RST;
				end else begin
					if (cfg[ch].wr) begin
						ocr_buf[ch] <= cfg[ch].data;
					end
					if (!is_pwm) begin
						ocr_act[ch] <= cfg[ch].wr ? cfg[ch].data : ocr_buf[ch];
					end else if (top_tick || bottom_tick) begin
						ocr_act[ch] <= ocr_buf[ch];
					end
				end
			end

			assign match = tick && !block_match && !cnt_wr_in.wr && cnt == ocr_act[ch];

			// a match at top acts as down-slope, at bottom as up-slope: extremes stay level
			assign pc_down = (count_down || cnt == top) && cnt != TMW_BOTTOM;

			// remembers whether this phase correct up-slope saw its match
			always_ff @(posedge clk_in or negedge resetn_in) begin
				if (!resetn_in) begin
					up_hit <= 1'b0;
				end else if (tick && cnt == TMW_BOTTOM) begin
					up_hit <= match;
				end else if (match && !count_down) begin
					up_hit <= 1'b1;
				end
			end

			// waveform state per mode and action code
			always_comb begin
				next_wave = wave;
				if (is_fast) begin
					if (cfg[ch].action == 2'h1 && ch == 0) begin
						if (match) next_wave = !wave;
					end else if (cfg[ch].action[1]) begin
						// at ocr == top the bottom set and match clear cancel to a level
						if (match && ocr_act[ch] == top) next_wave = !cfg[ch].action[0];
						else if (match) next_wave = cfg[ch].action[0];
						else if (bottom_tick) next_wave = !cfg[ch].action[0];
					end
				end else if (is_pc) begin
					if (cfg[ch].action[1]) begin
						if (match) begin
							next_wave = pc_down ^ cfg[ch].action[0];
						end else if (tick && count_down && cnt == TMW_BOTTOM && !up_hit) begin
							next_wave = count_down ^ cfg[ch].action[0];
						end
					end
				end else if (match) begin
					case (cfg[ch].action)
						2'h1:    next_wave = !wave;
						2'h2:    next_wave = 1'b0;
						2'h3:    next_wave = 1'b1;
						default: next_wave = wave;
					endcase
				end
			end

			always_ff @(posedge clk_in or negedge resetn_in) begin
				if (!resetn_in) begin
					wave <= TMW_WAVE_RST;
				end else begin
					wave <= next_wave;
				end
			end

			// match flag: set wins over clear; ctc sets channel a's at top
			always_ff @(posedge clk_in or negedge resetn_in) begin
				if (!resetn_in) begin
					compare_flag_out[ch] <= 1'b0;
				end else if (match) begin
					compare_flag_out[ch] <= 1'b1;
				end else if (compare_clear_in[ch]) begin
					compare_flag_out[ch] <= 1'b0;
				end
			end

			assign wave_output_out[ch] = wave;
			// pin shows the wave whenever direction out is set, whatever the action
			assign pin_drive_out[ch] = wave;
			assign pin_oe_out[ch]    = cfg[ch].dir_out;

			a_pin_gated: assert property (@(posedge clk_in) disable iff (!resetn_in)
				!cfg[ch].dir_out |-> !pin_oe_out[ch])
				else $error("pin enabled without direction out");
		end
	endgenerate

	assign compare_a_value_out = ocr_buf[0];
	assign compare_b_value_out = ocr_buf[1];

	////////////////////////////////////////////////////////////////////////////////
	// checks

	a_norm_wrap: assert property (@(posedge clk_in) disable iff (!resetn_in)
		(mode == TMW_NORMAL && tick && !cnt_wr_in.wr && cnt == TMW_MAX)
		|=> (cnt == TMW_BOTTOM && overflow_flag_out))
		else $error("normal mode wrap or overflow wrong");
	a_norm_incr: assert property (@(posedge clk_in) disable iff (!resetn_in)
		(mode == TMW_NORMAL && tick && !cnt_wr_in.wr) |=> cnt == $past(cnt) + 8'h01)
		else $error("normal mode did not increment");
	a_ctc_clear: assert property (@(posedge clk_in) disable iff (!resetn_in)
		(mode == TMW_CTC && tick && !cnt_wr_in.wr && !block_match && cnt == ocr_act[0])
		|=> cnt == TMW_BOTTOM)
		else $error("ctc did not clear at compare");
	a_ctc_flag: assert property (@(posedge clk_in) disable iff (!resetn_in)
		(mode == TMW_CTC && tick && !cnt_wr_in.wr && !block_match && cnt == ocr_act[0])
		|=> compare_flag_out[0])
		else $error("ctc compare flag missing");
	a_stop_hold: assert property (@(posedge clk_in) disable iff (!resetn_in)
		(clock_select_in == 3'h0 && !cnt_wr_in.wr) |=> $stable(cnt))
		else $error("counter moved while stopped");
	a_write_wins: assert property (@(posedge clk_in) disable iff (!resetn_in)
		cnt_wr_in.wr |=> cnt == $past(cnt_wr_in.data))
		else $error("count write lost");
	a_fast_wrap: assert property (@(posedge clk_in) disable iff (!resetn_in)
		(is_fast && tick && !cnt_wr_in.wr && cnt == top)
		|=> (cnt == TMW_BOTTOM && overflow_flag_out))
		else $error("fast pwm top handling wrong");
	a_pc_turn: assert property (@(posedge clk_in) disable iff (!resetn_in)
		(is_pc && tick && !cnt_wr_in.wr && !count_down && cnt == top && top != TMW_BOTTOM)
		|=> (count_down && cnt == $past(cnt) - 8'h01))
		else $error("phase correct did not turn at top");
	a_pc_ovf: assert property (@(posedge clk_in) disable iff (!resetn_in)
		(is_pc && tick && !cnt_wr_in.wr && count_down && cnt == TMW_BOTTOM)
		|=> overflow_flag_out)
		else $error("phase correct overflow missing");
	a_tick_rate: assert property (@(posedge clk_in) disable iff (!resetn_in)
		(clock_select_in == 3'h2 && tick) ##1 (clock_select_in == 3'h2) [*7]
		|-> !$past(tick) ##1 (clock_select_in != 3'h2 || tick))
		else $error("divide by 8 tick spacing wrong");
endmodule

// ==== testbench/tb.sv ====
// self-checking bench for the timer waveform core
`timescale 1ns/1ps
module tb;
	import tmw_pkg::*;
	logic          clk_in;
	logic          resetn_in;
	logic [2:0]    cs;
	logic [2:0]    mode;
	tmw_cnt_wr_t   cnt_wr;
	tmw_chan_cfg_t chan_a;
	tmw_chan_cfg_t chan_b;
	logic          ov_clr;
	logic [1:0]    cmp_clr;
	logic [7:0]    cnt;
	logic [7:0]    cmp_a;
	logic [7:0]    cmp_b;
	logic          ov;
	logic [1:0]    cflag;
	logic [1:0]    wave;
	logic [1:0]    drive;
	logic [1:0]    oe;
	logic          tick;
	logic [7:0]    ra;
	logic [7:0]    rb;
	logic [7:0]    pv;
	logic          pw;
	int            n_mismatch = 0;
	int            checks_done = 0;
	int            maxc, hi_a, hi_b, tog, ticks, topn, ovn, cfa, cfb, pinbad;
	int            dv[8] = '{0, 1, 8, 32, 64, 128, 256, 1024};

	tmw_timer8 dut (
		.clk_in                  (clk_in),
		.resetn_in               (resetn_in),
		.clock_select_in         (cs),
		.waveform_mode_select_in (mode),
		.cnt_wr_in               (cnt_wr),
		.chan_a_in               (chan_a),
		.chan_b_in               (chan_b),
		.overflow_clear_in       (ov_clr),
		.compare_clear_in        (cmp_clr),
		.counter_value_out       (cnt),
		.compare_a_value_out     (cmp_a),
		.compare_b_value_out     (cmp_b),
		.overflow_flag_out       (ov),
		.compare_flag_out        (cflag),
		.wave_output_out         (wave),
		.pin_drive_out           (drive),
		.pin_oe_out              (oe),
		.timer_tick_out          (tick)
	);

	////////////////////////////////////////////////////////////////////////
	// 125 MHz clock
	initial begin
		clk_in = 1'b0;
		forever #4 clk_in = ~clk_in;
	end

	// cuts a hang short; the whole run needs well under 40k cycles
	initial begin
		#600000;
		n_mismatch++;
		end_sim();
	end

	////////////////////////////////////////////////////////////////////////
	// expected high cycles per period; set at bottom, cleared at match
	function automatic int fast_hi(input int o, input logic inv);
		return inv ? 255 - o : o + 1;
	endfunction

	// dual slope: low while the count sits above the compare value
	function automatic int pc_hi(input int o, input logic inv);
		return inv ? 510 - 2 * o : 2 * o;
	endfunction

	task automatic chk(input logic ok, input string msg);
		checks_done++;
		if (ok !== 1'b1) begin
			n_mismatch++;
			$display("Error at %0t: %s", $time, msg);
		end
	endtask

	task automatic end_sim();
		$display("mismatches %0d, checks %0d", n_mismatch, checks_done);
		if (n_mismatch == 0 && checks_done > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// flag clears held high until wait_zero, so each set event shows as one high cycle
	task automatic run(input int n, input logic [7:0] top);
		{maxc, hi_a, hi_b, tog, ticks, topn, ovn, cfa, cfb, pinbad} = '0;
		pw = wave[0];
		ov_clr = 1'b1;
		cmp_clr = 2'b11;
		repeat (n) begin
			@(negedge clk_in);
			if (cnt > maxc) maxc = cnt;
			hi_a += (wave[0] === 1'b1);
			hi_b += (wave[1] === 1'b1);
			tog += (wave[0] !== pw);
			pw = wave[0];
			ticks += (tick === 1'b1);
			topn += (cnt === top);
			ovn += (ov === 1'b1);
			cfa += (cflag[0] === 1'b1);
			cfb += (cflag[1] === 1'b1);
			if (oe !== {chan_b.dir_out, chan_a.dir_out} || (oe[0] && drive[0] !== wave[0]))
				pinbad++;
		end
		chk(pinbad == 0, "pin drive or enable wrong");
	endtask

	task automatic wr_cnt(input logic [7:0] v);
		cnt_wr = '{wr: 1'b1, data: v};
		@(negedge clk_in);
		cnt_wr.wr = 1'b0;
	endtask

	// new mode and compares, then long enough for buffered values to load
	task automatic cfg(input logic [2:0] m, input logic [1:0] aa, ab, input logic [7:0] a, b);
		mode = m;
		chan_a.action = aa;
		chan_b.action = ab;
		chan_a.dir_out = 1'($urandom);
		chan_b.dir_out = 1'($urandom);
		{chan_a.wr, chan_a.data, chan_b.wr, chan_b.data} = {1'b1, a, 1'b1, b};
		@(negedge clk_in);
		{chan_a.wr, chan_b.wr} = 2'b00;
		run(1100, 8'h00);
	endtask

	// releases the flag clears so the overflow flag stands once it is set
	task automatic wait_zero();
		ov_clr = 1'b0;
		cmp_clr = 2'b00;
		pv = cnt;
		for (int i = 0; i < 300 && cnt !== 8'h00; i++) begin
			pv = cnt;
			@(negedge clk_in);
		end
	endtask

	////////////////////////////////////////////////////////////////////////
	// main sequence, inputs change on the falling edge
	initial begin
		{resetn_in, cs, mode, cnt_wr, chan_a, chan_b, ov_clr, cmp_clr} = '0;
		void'($urandom(32'he8f9));
		repeat (20) @(negedge clk_in);
		resetn_in = 1'b1;
		@(negedge clk_in);
		chk(cnt === 8'h00 && ov === 1'b0 && cflag === 2'b00 && wave === 2'b00, "reset");
		wr_cnt(8'hfd);
		run(20, 8'hfd);
		chk(topn == 20 && ticks == 0, "stopped counter moved");
		chan_a.action = 2'($urandom);
		chan_b.action = 2'($urandom);
		cs = 3'd1;
		wait_zero();
		chk(pv === 8'hff && ov === 1'b1, "wrap or overflow");
		run(512, 8'h00);
		chk(maxc == 255 && ovn == 2 && topn == 2, "normal count");
		for (int c = 1; c < 8; c++) begin
			cs = 3'(c);
			run(2048, 8'h00);
			chk(ticks >= 2048 / dv[c] - 1 && ticks <= 2048 / dv[c] + 1, "tick rate");
		end
		cs = 3'd1;
		ra = 8'($urandom_range(40, 4));
		cfg(3'd2, 2'd1, 2'd0, ra, 8'h00);
		run(4 * (ra + 1), 8'h00);
		chk(maxc == ra && tog == 4 && cfa == 4 && ovn == 0, "ctc");
		chk(cfb == 4, "ctc channel b flag");
		// a count write lands at once and hides the following match
		wr_cnt(ra);
		chk(cnt === ra, "count write");
		@(negedge clk_in);
		chk(cnt === ra + 8'h01, "match not blocked");
		wait_zero();
		chk(pv === 8'hff && ov === 1'b1, "ctc run past top");
		// extreme compare a values first, then a random one; compare b is random every time
		for (int k = 0; k < 3; k++) begin
			ra = (k == 0) ? 8'h00 : (k == 1) ? 8'hff : 8'($urandom);
			rb = 8'($urandom);
			cfg(3'd3, 2'd2, 2'd3, ra, rb);
			run(256, 8'hff);
			chk(hi_a == fast_hi(ra, 0) && hi_b == fast_hi(rb, 1), "fast duty");
			chk(maxc == 255 && topn == 1 && ovn == 1, "fast count");
			cfg(3'd1, 2'd2, 2'd3, ra, rb);
			run(510, 8'hff);
			chk(hi_a == pc_hi(ra, 0) && hi_b == pc_hi(rb, 1), "pc duty");
			chk(maxc == 255 && topn == 1 && ovn == 1, "pc count");
			chk(cmp_b === rb, "compare b readback");
		end
		ra = 8'($urandom_range(200, 20));
		cfg(3'd7, 2'd1, 2'd0, ra, 8'h00);
		run(2 * (ra + 1), ra);
		chk(maxc == ra && tog == 2 && ovn == 2 && topn == 2, "fast top a");
		chk(cmp_a === ra, "compare readback");
		cfg(3'd5, 2'd0, 2'd2, ra, rb);
		run(2 * ra, ra);
		chk(maxc == ra && topn == 1 && ovn == 1, "pc top a");
		end_sim();
	end
endmodule
